// >>> hdl/dmpt_pkg.sv
// Package of the dual-mode PWM timer: register offsets, field layouts,
// reset values, count source codes, states and carrier structs.
// Assumes a 100 MHz system clock and a plain register port with 10-bit byte addresses.
package dmpt_pkg;

  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PIN_N = 4;

  localparam logic [ADDR_W-1:0] OFF_MODE = 10'h120;
  localparam logic [ADDR_W-1:0] OFF_CTRL_ONE = 10'h121;
  localparam logic [ADDR_W-1:0] OFF_CNT = 10'h126;
  localparam logic [ADDR_W-1:0] OFF_CMP_A = 10'h128;
  localparam logic [ADDR_W-1:0] OFF_CMP_B = 10'h12A;
  localparam logic [ADDR_W-1:0] OFF_CMP_C = 10'h12C;
  localparam logic [ADDR_W-1:0] OFF_CMP_D = 10'h12E;
  localparam logic [ADDR_W-1:0] OFF_CTRL_TWO = 10'h130;

  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h18;
  localparam logic [7:0] CTRL_TWO_FIXED_ONES = 8'h18;
  localparam logic [7:0] MODE_WR_MASK = 8'hBF;
  localparam logic [15:0] CMP_RST = 16'hFFFF;
  localparam logic [15:0] CNT_RST = 16'h0000;

  // Prescaler masks: a tick when all masked prescaler bits are one
  localparam logic [4:0] PRE_MASK_F1 = 5'h00;
  localparam logic [4:0] PRE_MASK_F2 = 5'h01;
  localparam logic [4:0] PRE_MASK_F4 = 5'h03;
  localparam logic [4:0] PRE_MASK_F8 = 5'h07;
  localparam logic [4:0] PRE_MASK_F32 = 5'h1F;

  typedef enum logic [2:0] {
    SRC_F1 = 3'h0,
    SRC_F2 = 3'h1,
    SRC_F4 = 3'h2,
    SRC_F8 = 3'h3,
    SRC_F32 = 3'h4,
    SRC_EXT = 3'h5,
    SRC_BAD6 = 3'h6,
    SRC_BAD7 = 3'h7
  } dmpt_src_e;

  typedef enum logic [1:0] {
    TRG_OFF = 2'h0,
    TRG_RISE = 2'h1,
    TRG_FALL = 2'h2,
    TRG_BOTH = 2'h3
  } dmpt_trg_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_ARMED = 3'b100
  } dmpt_state_e;

  typedef struct packed {
    logic counter_clear_select;
    dmpt_src_e count_source;
    logic initial_level_d;
    logic initial_level_c;
    logic initial_level_b;
    logic initial_level_a;
  } dmpt_ctrl1_s;

  typedef struct packed {
    dmpt_trg_e trigger_edge;
    logic count_stop_select;
    logic [1:0] fixed_ones;
    logic polarity_d;
    logic polarity_c;
    logic polarity_b;
  } dmpt_ctrl2_s;

  typedef struct packed {
    logic count_start_bit;
    logic running;
    logic buffer_enable_d;
    logic buffer_enable_c;
    logic pwm2_mode;
    logic pwm_en_d;
    logic pwm_en_c;
    logic pwm_en_b;
  } dmpt_mode_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dmpt_bus_req_s;

  typedef struct packed {
    logic overflow;
    logic match_d;
    logic match_c;
    logic match_b;
    logic match_a;
  } dmpt_irq_s;

endpackage

// >>> hdl/dmpt_timer.sv
// Dual-mode PWM timer: 16-bit up counter with multi-channel PWM and one-shot PWM2 modes.
// Assumes a same-clock register master (one-cycle strobes, read data the next cycle);
// the pin A input and the count clock are asynchronous and are synchronised here. Pin vectors index 0=A .. 3=D.
//
// Notes on behaviour
// - Up to three PWM pins, each PWM or port
// - Any PWM pin makes register A the period
// - Three-bit field selects count clock source
// - Count per source tick; period is A+1
// - Inactive n+1 cycles, then active m-n cycles
// - Clear select: free-run or clear at A
// - Start bit begins counting; configure while stopped
// - Start bit cleared stops, levels and count kept
// - Stop select halts at period match, levels inactive
// - Match A-D and overflow raise request pulses
// - Initial level per pin, applied on write
// - Polarity bit picks active high or low
// - Change points B,C,D; buffers retarget C,D
// - Change point equal to period never toggles
// - PWM2 one-shot: wait C+1, active B-C
// - PWM2 excludes other modes; C,D are ports
// - Trigger edge field: off, rise, fall, both
// - PWM2 starts by start bit or trigger edge
// - PWM2 start cleared: output B to initial
// - PWM2 requests on A,B,C match and overflow
// - PWM2 initial level of B sets polarity
`timescale 1ns/1ps

module dmpt_timer
  import dmpt_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire dmpt_bus_req_s bus_req,
  output logic [DATA_W-1:0] bus_rdata,
  input wire logic [PIN_N-1:0] pin_i,
  input wire logic ext_count_clk_i,
  input wire logic [PIN_N-1:0] port_out,
  input wire logic [PIN_N-1:0] port_oe,
  output logic [PIN_N-1:0] pin_o,
  output logic [PIN_N-1:0] pin_oe,
  output dmpt_irq_s irq_src
);

  if (CNT_W != DATA_W) begin : g_width_check
    $error("dmpt_timer: counter width must equal bus width");
  end

  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  dmpt_mode_s mode_ff;
  dmpt_ctrl1_s ctrl1_ff;
  dmpt_ctrl2_s ctrl2_ff;
  dmpt_state_e state_ff;
  dmpt_state_e nxt_state;
  dmpt_irq_s irq_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] cmp_a_ff;
  logic [CNT_W-1:0] cmp_b_ff;
  logic [CNT_W-1:0] cmp_c_ff;
  logic [CNT_W-1:0] cmp_d_ff;
  logic [4:0] pre_ff;
  logic trg_s1_ff;
  logic trg_s2_ff;
  logic trg_s3_ff;
  logic ext_s1_ff;
  logic ext_s2_ff;
  logic ext_s3_ff;
  logic [2:0] act_ff;
  logic [PIN_N-1:0] pin_o_ff;
  logic [PIN_N-1:0] pin_oe_ff;
  logic [DATA_W-1:0] rdata_ff;

  logic wr_mode;
  logic wr_ctrl1;
  logic wr_ctrl2;
  logic wr_cnt;
  dmpt_mode_s wmode;
  logic start_wr1;
  logic start_wr0;
  logic src_tick;
  logic run_tick;
  logic m_a;
  logic m_b;
  logic m_c;
  logic m_d;
  logic pwm2;
  logic [2:0] pwm_ch;
  logic pwm_any;
  logic trig_mode;
  logic trig_edge;
  logic stop_at_a;
  logic cnt_clr;
  logic [CNT_W-1:0] chg [3];
  logic [2:0] chg_valid;

  function automatic logic wr_hit(input dmpt_bus_req_s req, input logic [ADDR_W-1:0] off);
    return req.wr && (req.addr == off);
  endfunction

  function automatic logic pre_tick(input logic [4:0] pre, input logic [4:0] mask);
    return (pre & mask) == mask;
  endfunction

  assign wr_mode = wr_hit(bus_req, OFF_MODE);
  assign wr_ctrl1 = wr_hit(bus_req, OFF_CTRL_ONE);
  assign wr_ctrl2 = wr_hit(bus_req, OFF_CTRL_TWO);
  assign wr_cnt = wr_hit(bus_req, OFF_CNT);
  assign wmode = dmpt_mode_s'(bus_req.wdata[7:0]);
  assign start_wr1 = wr_mode && wmode.count_start_bit && !mode_ff.count_start_bit;
  assign start_wr0 = wr_mode && !wmode.count_start_bit;

  // PWM2 takes compare registers A, B and C, so per-pin PWM is ignored while it is on
  assign pwm2 = mode_ff.pwm2_mode;
  assign pwm_ch = pwm2 ? 3'b000 : {mode_ff.pwm_en_d, mode_ff.pwm_en_c, mode_ff.pwm_en_b};
  assign pwm_any = pwm2 || (|pwm_ch);
  assign trig_mode = pwm2 && (ctrl2_ff.trigger_edge != TRG_OFF) && ctrl2_ff.count_stop_select;
  assign stop_at_a = ctrl2_ff.count_stop_select && pwm_any;

  // Count source select; codes 6 and 7 give no tick
  always_comb begin
    unique case (ctrl1_ff.count_source)
      SRC_F1: src_tick = 1'b1;
      SRC_F2: src_tick = pre_tick(pre_ff, PRE_MASK_F2);
      SRC_F4: src_tick = pre_tick(pre_ff, PRE_MASK_F4);
      SRC_F8: src_tick = pre_tick(pre_ff, PRE_MASK_F8);
      SRC_F32: src_tick = pre_tick(pre_ff, PRE_MASK_F32);
      SRC_EXT: src_tick = ext_s2_ff && !ext_s3_ff;
      default: src_tick = 1'b0;
    endcase
  end

  always_comb begin
    unique case (ctrl2_ff.trigger_edge)
      TRG_RISE: trig_edge = trg_s2_ff && !trg_s3_ff;
      TRG_FALL: trig_edge = !trg_s2_ff && trg_s3_ff;
      TRG_BOTH: trig_edge = trg_s2_ff ^ trg_s3_ff;
      default: trig_edge = 1'b0;
    endcase
  end

  assign run_tick = (state_ff == ST_RUN) && src_tick;
  assign m_a = run_tick && (cnt_ff == cmp_a_ff);
  assign m_b = run_tick && (cnt_ff == cmp_b_ff);
  assign m_c = run_tick && (cnt_ff == cmp_c_ff);
  assign m_d = run_tick && (cnt_ff == cmp_d_ff);

  // A PWM2 stop clears only when clear select is set; otherwise A clears as period
  always_comb begin
    if (pwm2 && stop_at_a) begin
      cnt_clr = m_a && ctrl1_ff.counter_clear_select;
    end else begin
      cnt_clr = m_a && (ctrl1_ff.counter_clear_select || pwm_any);
    end
  end

  // Change points; a buffered C or D is no longer a change point of its own pin
  assign chg[0] = cmp_b_ff;
  assign chg[1] = cmp_c_ff;
  assign chg[2] = cmp_d_ff;
  assign chg_valid = {pwm_ch[2] && !mode_ff.buffer_enable_d, pwm_ch[1] && !mode_ff.buffer_enable_c, pwm_ch[0]};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 5'h00;
    end else begin
      pre_ff <= pre_ff + 5'h01;
    end
  end

  // Two-stage synchronisers; the third stage only feeds the edge detectors
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trg_s1_ff <= 1'b0;
      trg_s2_ff <= 1'b0;
      trg_s3_ff <= 1'b0;
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
    end else begin
      trg_s1_ff <= pin_i[0];
      trg_s2_ff <= trg_s1_ff;
      trg_s3_ff <= trg_s2_ff;
      ext_s1_ff <= ext_count_clk_i;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (start_wr1) begin
          nxt_state = trig_mode ? ST_ARMED : ST_RUN;
        end
      end
      ST_RUN: begin
        if (start_wr0) begin
          nxt_state = ST_IDLE;
        end else if (m_a && stop_at_a) begin
          nxt_state = trig_mode ? ST_ARMED : ST_IDLE;
        end
      end
      ST_ARMED: begin
        if (start_wr0) begin
          nxt_state = ST_IDLE;
        end else if (trig_edge) begin
          nxt_state = ST_RUN;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Hardware drops the start bit at an auto stop; a software set in that cycle wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= dmpt_mode_s'(MODE_RST);
    end else begin
      if (m_a && stop_at_a && !trig_mode) begin
        mode_ff.count_start_bit <= 1'b0;
      end
      if (wr_mode) begin
        mode_ff <= dmpt_mode_s'(bus_req.wdata[7:0] & MODE_WR_MASK);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_ff <= dmpt_ctrl1_s'(CTRL_ONE_RST);
      ctrl2_ff <= dmpt_ctrl2_s'(CTRL_TWO_RST);
    end else begin
      if (wr_ctrl1) begin
        ctrl1_ff <= dmpt_ctrl1_s'(bus_req.wdata[7:0]);
      end
      if (wr_ctrl2) begin
        ctrl2_ff <= dmpt_ctrl2_s'(bus_req.wdata[7:0] | CTRL_TWO_FIXED_ONES);
      end
    end
  end

  // Clear by period match wins over a software write in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= CNT_RST;
    end else if (cnt_clr) begin
      cnt_ff <= CNT_RST;
    end else if (wr_cnt) begin
      cnt_ff <= bus_req.wdata;
    end else if (run_tick && !(m_a && stop_at_a)) begin
      cnt_ff <= cnt_ff + CNT_W'(1);
    end
  end

  // Buffer copy at period match; a software write in the same cycle wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_a_ff <= CMP_RST;
      cmp_b_ff <= CMP_RST;
      cmp_c_ff <= CMP_RST;
      cmp_d_ff <= CMP_RST;
    end else begin
      if (m_a && mode_ff.buffer_enable_c) begin
        cmp_a_ff <= cmp_c_ff;
      end
      if (m_a && mode_ff.buffer_enable_d) begin
        cmp_b_ff <= cmp_d_ff;
      end
      if (wr_hit(bus_req, OFF_CMP_A)) begin
        cmp_a_ff <= bus_req.wdata;
      end
      if (wr_hit(bus_req, OFF_CMP_B)) begin
        cmp_b_ff <= bus_req.wdata;
      end
      if (wr_hit(bus_req, OFF_CMP_C)) begin
        cmp_c_ff <= bus_req.wdata;
      end
      if (wr_hit(bus_req, OFF_CMP_D)) begin
        cmp_d_ff <= bus_req.wdata;
      end
    end
  end

  // Active-state of channels B, C, D (1 = active level)
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      act_ff <= 3'b000;
    end else if (pwm2) begin
      if (wr_ctrl1 || start_wr0 || (m_a && stop_at_a)) begin
        act_ff[0] <= 1'b0;
      end else if (m_c) begin
        act_ff[0] <= 1'b1;
      end else if (m_b) begin
        act_ff[0] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_ctrl1) begin
          act_ff[i] <= bus_req.wdata[i+1];
        end else if (chg_valid[i] && run_tick && (chg[i] != cmp_a_ff)) begin
          if (m_a) begin
            act_ff[i] <= 1'b0;
          end else if (cnt_ff == chg[i]) begin
            act_ff[i] <= 1'b1;
          end
        end
        // An equal change point and period leaves the level alone
      end
    end
  end

  // Pins: A is always a port (or trigger input); PWM pins other than a buffered C or D drive their level
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_o_ff <= '0;
      pin_oe_ff <= '0;
    end else begin
      pin_o_ff <= port_out;
      pin_oe_ff <= port_oe;
      if (pwm2) begin
        pin_o_ff[1] <= act_ff[0] ^ ctrl1_ff.initial_level_b;
        pin_oe_ff[1] <= 1'b1;
      end else begin
        for (int i = 0; i < 3; i++) begin
          if (chg_valid[i]) begin
            pin_o_ff[i+1] <= act_ff[i] ~^ ctrl2_ff[i];
            pin_oe_ff[i+1] <= 1'b1;
          end
        end
      end
    end
  end

  // Request pulses; D match is not a source in PWM2
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff <= '0;
    end else begin
      irq_ff.match_a <= m_a;
      irq_ff.match_b <= m_b;
      irq_ff.match_c <= m_c;
      irq_ff.match_d <= m_d && !pwm2;
      irq_ff.overflow <= run_tick && (cnt_ff == CNT_MAX) && !cnt_clr;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        OFF_MODE: rdata_ff <= {8'h00, mode_ff.count_start_bit, state_ff == ST_RUN, mode_ff[5:0]};
        OFF_CTRL_ONE: rdata_ff <= {8'h00, ctrl1_ff};
        OFF_CTRL_TWO: rdata_ff <= {8'h00, ctrl2_ff};
        OFF_CNT: rdata_ff <= cnt_ff;
        OFF_CMP_A: rdata_ff <= cmp_a_ff;
        OFF_CMP_B: rdata_ff <= cmp_b_ff;
        OFF_CMP_C: rdata_ff <= cmp_c_ff;
        OFF_CMP_D: rdata_ff <= cmp_d_ff;
        default: rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign bus_rdata = rdata_ff;
  assign pin_o = pin_o_ff;
  assign pin_oe = pin_oe_ff;
  assign irq_src = irq_ff;

endmodule

// >>> tb/dmpt_timer_props.sv
// Checker of the dual-mode PWM timer, watching only the timer's ports.
// Assumes one clock domain; bound to every timer instance at the foot of this file.
`timescale 1ns/1ps
module dmpt_timer_chk
  import dmpt_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire dmpt_bus_req_s bus_req,
  input wire logic [DATA_W-1:0] bus_rdata,
  input wire logic [PIN_N-1:0] pin_i,
  input wire logic ext_count_clk_i,
  input wire logic [PIN_N-1:0] port_out,
  input wire logic [PIN_N-1:0] port_oe,
  input wire logic [PIN_N-1:0] pin_o,
  input wire logic [PIN_N-1:0] pin_oe,
  input wire dmpt_irq_s irq_src
);
  logic [7:0] sh_mode_ff;
  logic [7:0] sh_c1_ff;
  logic [7:0] sh_c2_ff;
  logic [2:0] idle_ff;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Shadows of written settings; the start bit may be stale after an automatic stop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sh_mode_ff <= MODE_RST;
      sh_c1_ff <= CTRL_ONE_RST;
      sh_c2_ff <= CTRL_TWO_RST;
    end else if (bus_req.wr) begin
      if (bus_req.addr == OFF_MODE) sh_mode_ff <= bus_req.wdata[7:0];
      if (bus_req.addr == OFF_CTRL_ONE) sh_c1_ff <= bus_req.wdata[7:0];
      if (bus_req.addr == OFF_CTRL_TWO) sh_c2_ff <= bus_req.wdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) idle_ff <= 3'h0;
    else if (bus_req.wr) idle_ff <= 3'h0;
    else if (idle_ff != 3'h7) idle_ff <= idle_ff + 3'h1;
  end

  sequence s_lvl_wr;
    bus_req.wr && bus_req.addr == OFF_CTRL_ONE && sh_mode_ff[0] && !sh_mode_ff[3] && !sh_mode_ff[7];
  endsequence

  sequence s_pwm2_halt;
    bus_req.wr && bus_req.addr == OFF_MODE && bus_req.wdata[3] && !bus_req.wdata[7];
  endsequence

  AST_INIT_LEVEL: assert property (s_lvl_wr ##1 !bus_req.wr [*2] |-> pin_o[1] == (sh_c1_ff[1] ~^ sh_c2_ff[0]))
    else $error("pin B initial level wrong");
  AST_PWM2_STOP_INIT: assert property (s_pwm2_halt ##1 !bus_req.wr [*3] |-> pin_o[1] == sh_c1_ff[1])
    else $error("pin B not back at initial level");
  AST_STOP_HOLD: assert property (sh_mode_ff[0] && !sh_mode_ff[3] && !sh_mode_ff[7] && idle_ff >= 3'h3 |-> $stable(pin_o[1]))
    else $error("stopped PWM pin moved");
  AST_SRC_BAD: assert property (sh_c1_ff[6:5] == 2'b11 && $past(sh_c1_ff[6:5], 3) == 2'b11 |-> irq_src == '0)
    else $error("request with prohibited source");
  AST_OVF_PULSE: assert property (irq_src.overflow |=> !irq_src.overflow)
    else $error("overflow request too long");
  AST_PWM2_NO_D: assert property (sh_mode_ff[3] && $past(sh_mode_ff[3]) |-> !irq_src.match_d)
    else $error("match D request in PWM2");
  AST_PWM2_CD_PORT: assert property (sh_mode_ff[3] && $past(sh_mode_ff[3]) |-> pin_o[3:2] == $past(port_out[3:2]) && pin_oe[3:2] == $past(port_oe[3:2]))
    else $error("pins C D not ports in PWM2");
  AST_PIN_A_PORT: assert property ($past(rst_n) |-> pin_o[0] == $past(port_out[0]) && pin_oe[0] == $past(port_oe[0]))
    else $error("pin A not a port");
  AST_PWM_B_DRIVEN: assert property (sh_mode_ff[0] && idle_ff >= 3'h3 |-> pin_oe[1])
    else $error("PWM pin B not driven");
endmodule

bind dmpt_timer dmpt_timer_chk #(.CNT_W(CNT_W)) u_chk (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .pin_i(pin_i), .ext_count_clk_i(ext_count_clk_i), .port_out(port_out),
  .port_oe(port_oe), .pin_o(pin_o), .pin_oe(pin_oe), .irq_src(irq_src));

// >>> tb/dmpt_far_end.sv
// Far-side model: loads on the timer pins, trigger source on pin A, external count clock.
// Assumes undriven pins B to D carry pull-ups; the count clock stands low outside bursts.
`timescale 1ns/1ps
module dmpt_far_end
  import dmpt_pkg::*;
(
  input wire logic mclk,
  input wire logic [PIN_N-1:0] pin_o,
  input wire logic [PIN_N-1:0] pin_oe,
  output logic [PIN_N-1:0] pin_i,
  output logic ext_clk
);
  logic trig_lvl;

  initial begin
    trig_lvl = 1'b0;
    ext_clk = 1'b0;
  end

  // Pin A carries the trigger source whenever the timer leaves it undriven
  always_comb begin
    for (int i = 0; i < PIN_N; i++) begin
      pin_i[i] = pin_oe[i] ? pin_o[i] : ((i == 0) ? trig_lvl : 1'b1);
    end
  end

  task automatic set_trig(input logic lv);
    @(posedge mclk);
    #2 trig_lvl = lv;
  endtask

  // Slow enough for the two-flop synchroniser to see each level
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge mclk);
      #2 ext_clk = 1'b1;
      repeat (3) @(posedge mclk);
      #2 ext_clk = 1'b0;
      repeat (2) @(posedge mclk);
    end
  endtask
endmodule

// >>> tb/dmpt_timer_tb.sv
// Testbench of the dual-mode PWM timer: register rows, then PWM, PWM2 and trigger cases.
// Assumes the far-side model on the pins and the checker bound to the timer.
`timescale 1ns/1ps
module dmpt_timer_tb
  import dmpt_pkg::*;
;
  typedef struct {logic [ADDR_W-1:0] a; logic [15:0] rv, wd, rb;} dmpt_row_s;
  logic mclk, rst_n, ext_clk;
  dmpt_bus_req_s bus_req;
  logic [DATA_W-1:0] bus_rdata, v;
  logic [PIN_N-1:0] pin_i, port_out, port_oe, pin_o, pin_oe;
  dmpt_irq_s irq_src;
  int miscompares = 0, checked = 0, cyc = 0, k;
  dmpt_row_s rows[9] = '{
    '{OFF_MODE, 16'h0000, 16'h0040, 16'h0000},
    '{OFF_CTRL_ONE, 16'h0000, 16'h008E, 16'h008E},
    '{OFF_CTRL_TWO, 16'h0018, 16'h0007, 16'h001F},
    '{OFF_CNT, 16'h0000, 16'h1234, 16'h1234},
    '{OFF_CMP_A, 16'hFFFF, 16'h00A5, 16'h00A5},
    '{OFF_CMP_B, 16'hFFFF, 16'h5A00, 16'h5A00},
    '{OFF_CMP_C, 16'hFFFF, 16'h0F0F, 16'h0F0F},
    '{OFF_CMP_D, 16'hFFFF, 16'hF0F0, 16'hF0F0},
    '{10'h122, 16'h0000, 16'hFFFF, 16'h0000}};

  dmpt_timer #(.CNT_W(16)) uut (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .pin_i(pin_i), .ext_count_clk_i(ext_clk), .port_out(port_out), .port_oe(port_oe), .pin_o(pin_o),
    .pin_oe(pin_oe), .irq_src(irq_src));
  dmpt_far_end far (.mclk(mclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i), .ext_clk(ext_clk));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    port_out <= port_out + 4'h1;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out;
    end
  end

  task automatic close_out;
    if (miscompares == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [15:0] e, input string nm);
    @(posedge mclk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    @(negedge mclk);
    v = bus_rdata;
    chk(nm, v, e);
  endtask

  task automatic ones(input int n);
    k = 0;
    repeat (n) @(negedge mclk) if (pin_o[1] === 1'b1) k++;
  endtask

  // Settings go in only while stopped
  task automatic start(input logic [15:0] c1, c2, m, cnt);
    wr(OFF_MODE, m);
    wr(OFF_CTRL_TWO, c2);
    wr(OFF_CNT, cnt);
    wr(OFF_CTRL_ONE, c1);
    repeat (3) @(posedge mclk);
    wr(OFF_MODE, m | 16'h0080);
  endtask

  initial begin
    int sh;
    int ov;
    rst_n = 1'b0;
    bus_req = '0;
    port_out = 4'h0;
    port_oe = 4'hC;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      rdc(rows[i].a, rows[i].rv, "reset value");
      wr(rows[i].a, rows[i].wd);
      rdc(rows[i].a, rows[i].rb, "read back");
    end
    wr(OFF_CMP_A, 16'h0007);
    wr(OFF_CMP_B, 16'h0002);
    for (int s = 0; s < 5; s++) begin
      for (int p = 0; p < 2; p++) begin
        sh = (s == 4) ? 5 : s;
        start(16'(s << 4), 16'(p), 16'h0001, 16'h0000);
        repeat (40) @(posedge mclk);
        ones(32 << sh);
        chk("pwm high cycles", 16'(k), 16'(p ? (20 << sh) : (12 << sh)));
      end
    end
    start(16'h0000, 16'h0001, 16'h0001, 16'h0000);
    wr(OFF_MODE, 16'h0001);
    rdc(OFF_CNT, 16'h0002, "count seen");
    repeat (40) @(posedge mclk);
    rdc(OFF_CNT, 16'h0002, "held count");
    wr(OFF_CMP_B, 16'h0007);
    for (int i = 0; i < 2; i++) begin
      start(16'(i << 1), 16'h0001, 16'h0001, 16'h0000);
      repeat (20) @(posedge mclk);
      ones(32);
      chk("flat duty", 16'(k), 16'(i * 32));
    end
    wr(OFF_CMP_B, 16'h0002);
    start(16'h0000, 16'h0021, 16'h0001, 16'h0000);
    repeat (30) @(posedge mclk);
    rdc(OFF_MODE, 16'h0001, "auto stop");
    chk("auto stop level", 16'(pin_o[1]), 16'h0000);
    wr(OFF_CMP_D, 16'h0005);
    start(16'h0000, 16'h0001, 16'h0021, 16'h0000);
    repeat (20) @(posedge mclk);
    ones(32);
    chk("buffered duty", 16'(k), 16'h0008);
    rdc(OFF_CMP_B, 16'h0005, "buffer copy");
    start(16'h0060, 16'h0000, 16'h0000, 16'h0000);
    repeat (20) @(posedge mclk);
    rdc(OFF_CNT, 16'h0000, "bad source");
    start(16'h0050, 16'h0000, 16'h0000, 16'hFFFA);
    ov = 0;
    fork
      far.ext_pulses(10);
      repeat (70) @(negedge mclk) if (irq_src.overflow === 1'b1) ov++;
    join
    repeat (5) @(posedge mclk);
    rdc(OFF_CNT, 16'h0004, "ext count");
    chk("overflow", 16'(ov), 16'h0001);
    wr(OFF_CMP_A, 16'h0014);
    wr(OFF_CMP_B, 16'h0008);
    wr(OFF_CMP_C, 16'h0003);
    for (int i = 0; i < 2; i++) begin
      start(16'(i * 8'h82), 16'h0020, 16'h000F, 16'h0000);
      ones(40);
      chk("one shot", 16'(k), 16'(i ? 35 : 5));
      rdc(OFF_MODE, 16'h000F, "one shot stop");
      rdc(OFF_CNT, 16'(i ? 0 : 20), "one shot count");
    end
    start(16'h0000, 16'h0020, 16'h000F, 16'h0000);
    repeat (4) @(posedge mclk);
    wr(OFF_MODE, 16'h000F);
    repeat (4) @(negedge mclk);
    chk("halt level", 16'(pin_o[1]), 16'h0000);
    rdc(OFF_CNT, 16'h0006, "halt count");
    for (int e = 1; e < 4; e++) begin
      start(16'h0080, 16'((e << 6) | 8'h20), 16'h000F, 16'h0000);
      ones(30);
      chk("armed", 16'(k), 16'h0000);
      far.set_trig(1'b1);
      ones(40);
      chk("rise trigger", 16'(k), 16'(e != 2 ? 5 : 0));
      far.set_trig(1'b0);
      ones(40);
      chk("fall trigger", 16'(k), 16'(e != 1 ? 5 : 0));
    end
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(OFF_MODE, 16'h0000, "reset mode");
    rdc(OFF_CMP_B, 16'hFFFF, "reset compare");
    close_out;
  end
endmodule
